// >>> verilog/dosm_pkg.sv
// Package of constants and types for the drive operating-state sequencer
package dosm_pkg;

  // ****************************************
  // Operating states, numbered 1 to 9
  // ****************************************
  typedef enum logic [3:0] {
    ST_START,
    ST_NOT_READY,
    ST_SWITCH_ON_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OPERATION_ENABLED,
    ST_QUICK_STOP_ACTIVE,
    ST_FAULT_RESPONSE_ACTIVE,
    ST_FAULT
  } dosm_state_e;

  // ****************************************
  // Fieldbus state-control command codes
  // ****************************************
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_SWITCH_ON = 3'h2;
  localparam logic [2:0] CMD_ENABLE_OPERATION = 3'h3;
  localparam logic [2:0] CMD_DISABLE_OPERATION = 3'h4;
  localparam logic [2:0] CMD_DISABLE_VOLTAGE = 3'h5;
  localparam logic [2:0] CMD_QUICK_STOP = 3'h6;
  localparam logic [2:0] CMD_FAULT_RESET = 3'h7;

  // ****************************************
  // Speed limit and error classes
  // ****************************************
  localparam logic [15:0] SPEED_LIMIT_RPM = 16'h03e8;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_CLASS1 = 3'h1;
  localparam logic [2:0] ERR_CLASS2 = 3'h2;
  localparam logic [2:0] ERR_CLASS3 = 3'h3;
  localparam logic [2:0] ERR_CLASS4 = 3'h4;

  // ****************************************
  // Status word bit positions and reset values
  // ****************************************
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_SWITCHED_ON_BIT = 1;
  localparam int STAT_OP_ENABLED_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_QUICK_STOP_BIT = 5;
  localparam int STAT_SWITCH_ON_DISABLED_BIT = 6;
  localparam logic [6:0] STATUS_RESET = 7'h00;
  localparam logic [1:0] FB_COMPAT_ONE = 2'h1;

endpackage : dosm_pkg

// >>> verilog/dosm_sequencer.sv
// Drive operating-state sequencer: states, power stage, brake and motion cancel
`timescale 1ns/100ps
// How it works
// - After reset, leave start on electronics init, then not-ready on parameter init.
// - Nine states encoded: start through fault, numbered one to nine.
// - State 3 to 4 needs no undervoltage, encoder ok, slow speed, both inputs high.
// - State 4 to 5 on local enable request or fieldbus Switch On.
// - State 5 to 6 automatic, unless reached by Switch On or Disable Operation; then wait Enable Operation.
// - Entering state 6 enables power stage, validates parameters, releases brake.
// - Disable Operation in 6 halts motion, applies brake, cuts power, goes to 5.
// - Shutdown in state 5 returns to state 4.
// - In 6, Shutdown goes to 4; disable or Disable Voltage goes to 3.
// - State 4 to 3 on undervoltage, both inputs low, overspeed or Disable Voltage.
// - In 5, disable request or Disable Voltage goes directly to 3.
// - In 6, class 1 error or Quick Stop enters 7 with quick stop.
// - In 7, disable or Disable Voltage goes to 3, power cut at once.
// - Class 2, 3 or 4 error from any state but 8 and 9 enters 8.
// - Class 2 in 6 or 7 goes 8 to 9 when response ends; otherwise directly.
// - Fault reset in 9 clears the error and returns to 3.
// - Fault reset returns 7 to 6; Enable Operation only if 7 came from fieldbus.
// - Fieldbus commands act only in fieldbus control mode.
// - Shutdown needed to leave 3 only with fieldbus, CANopen and compat one.
// - State shown on status word bits 0, 1, 2, 3, 5 and 6.
module dosm_sequencer
(
  input wire logic CLOCK,                  // System clock, 25 MHz
  input wire logic SYS_RST,                // Synchronous reset, active high
  input wire logic CLK_EN,                 // Clock enable, freezes all state when low
  input wire logic ELEC_INIT_DONE,         // Electronics initialization complete
  input wire logic PARAM_INIT_DONE,        // Parameter initialization complete
  input wire logic UNDERVOLTAGE,           // DC bus undervoltage
  input wire logic ENCODER_OK,             // Encoder check passed
  input wire logic [15:0] SPEED_RPM,       // Actual speed magnitude, rpm
  input wire logic SAFE_TORQUE_INPUT_A,    // Safe torque input A pin
  input wire logic SAFE_TORQUE_INPUT_B,    // Safe torque input B pin
  input wire logic LOCAL_ENABLE_REQ,       // Local power-stage enable request pulse
  input wire logic LOCAL_DISABLE_REQ,      // Local power-stage disable request pulse
  input wire logic LOCAL_FAULT_RESET,      // Local fault reset pulse
  input wire logic FIELDBUS_MODE,          // Fieldbus control mode selected
  input wire logic FIELDBUS_CANOPEN,       // Fieldbus is CANopen
  input wire logic [1:0] PROFILE_COMPAT_SELECT, // Compatibility setting
  input wire logic CMD_VALID,              // Fieldbus command strobe
  input wire logic [2:0] CMD_CODE,         // Fieldbus command code
  input wire logic [2:0] ERR_CLASS,        // Error class event, zero for none
  input wire logic ERR_RESPONSE_DONE,      // Class 2 braking response finished
  output logic POWER_STAGE_EN,             // Power stage enable
  output logic BRAKE_RELEASE,              // Holding brake released
  output logic PARAM_VALIDATE,             // Validate user parameters pulse
  output logic CANCEL_HALT,                // Cancel motion with halt pulse
  output logic CANCEL_QUICK_STOP,          // Quick stop braking active
  output logic ERROR_CLEAR,                // Error clear pulse
  output logic [3:0] STATE_NUM,            // Current state number 1 to 9
  output logic [6:0] DRIVE_STATUS_WORD     // Status word bits 6:0, bit 4 zero
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] sync_d;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;

  always_comb
  begin
    sync_d = {SAFE_TORQUE_INPUT_B, SAFE_TORQUE_INPUT_A};
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end
    else if (CLK_EN)
    begin
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic fb_cmd(input logic v, input logic mode, input logic [2:0] code,
                                  input logic [2:0] want);
    fb_cmd = v && mode && (code == want);
  endfunction : fb_cmd

  function automatic logic [6:0] status_of(input dosm_pkg::dosm_state_e s);
    logic [6:0] w;
    w = dosm_pkg::STATUS_RESET;
    case (s)
      dosm_pkg::ST_SWITCH_ON_DISABLED: w[dosm_pkg::STAT_SWITCH_ON_DISABLED_BIT] = 1'b1;
      dosm_pkg::ST_READY:
      begin
        w[dosm_pkg::STAT_QUICK_STOP_BIT] = 1'b1;
        w[dosm_pkg::STAT_READY_BIT] = 1'b1;
      end
      dosm_pkg::ST_SWITCHED_ON:
      begin
        w[dosm_pkg::STAT_QUICK_STOP_BIT] = 1'b1;
        w[dosm_pkg::STAT_SWITCHED_ON_BIT] = 1'b1;
        w[dosm_pkg::STAT_READY_BIT] = 1'b1;
      end
      dosm_pkg::ST_OPERATION_ENABLED:
      begin
        w[dosm_pkg::STAT_QUICK_STOP_BIT] = 1'b1;
        w[2:0] = 3'h7;
      end
      dosm_pkg::ST_QUICK_STOP_ACTIVE: w[2:0] = 3'h7;
      dosm_pkg::ST_FAULT_RESPONSE_ACTIVE, dosm_pkg::ST_FAULT:
      begin
        w[dosm_pkg::STAT_FAULT_BIT] = 1'b1;
        w[2:0] = 3'h7;
      end
      default: w = dosm_pkg::STATUS_RESET;
    endcase
    status_of = w;
  endfunction : status_of

  logic sto_high;
  logic sto_low;
  logic slow;
  logic fast;
  logic c_shut;
  logic c_on;
  logic c_enop;
  logic c_disop;
  logic c_disv;
  logic c_qs;
  logic c_frst;
  logic shut_needed;
  logic fault_reset;
  logic err_severe;

  always_comb
  begin
    sto_high = sync2_q[0] && sync2_q[1];
    sto_low = !sync2_q[0] && !sync2_q[1];
    slow = SPEED_RPM < dosm_pkg::SPEED_LIMIT_RPM;
    fast = SPEED_RPM > dosm_pkg::SPEED_LIMIT_RPM;
    c_shut = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_SHUTDOWN);
    c_on = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_SWITCH_ON);
    c_enop = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_ENABLE_OPERATION);
    c_disop = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_DISABLE_OPERATION);
    c_disv = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_DISABLE_VOLTAGE);
    c_qs = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_QUICK_STOP);
    c_frst = fb_cmd(CMD_VALID, FIELDBUS_MODE, CMD_CODE, dosm_pkg::CMD_FAULT_RESET);
    shut_needed = FIELDBUS_MODE && FIELDBUS_CANOPEN
                  && (PROFILE_COMPAT_SELECT == dosm_pkg::FB_COMPAT_ONE);
    fault_reset = LOCAL_FAULT_RESET || c_frst;
    err_severe = (ERR_CLASS == dosm_pkg::ERR_CLASS2) || (ERR_CLASS == dosm_pkg::ERR_CLASS3)
                 || (ERR_CLASS == dosm_pkg::ERR_CLASS4);
  end

  // ****************************************
  // State sequencer
  // ****************************************
  dosm_pkg::dosm_state_e state_d;
  dosm_pkg::dosm_state_e state_q;
  logic via_fb_d;
  logic via_fb_q;
  logic qs_fb_d;
  logic qs_fb_q;
  logic class2_d;
  logic class2_q;
  logic halt_d;
  logic err_clr_d;
  logic running;

  always_comb
  begin
    running = state_q == dosm_pkg::ST_OPERATION_ENABLED || state_q == dosm_pkg::ST_QUICK_STOP_ACTIVE;
    state_d = state_q;
    via_fb_d = via_fb_q;
    qs_fb_d = qs_fb_q;
    class2_d = class2_q;
    halt_d = 1'b0;
    err_clr_d = 1'b0;
    if ((err_severe || (running && !sto_high)) && state_q != dosm_pkg::ST_FAULT_RESPONSE_ACTIVE
        && state_q != dosm_pkg::ST_FAULT)
    begin
      state_d = dosm_pkg::ST_FAULT_RESPONSE_ACTIVE;
      // Soft braking only with the stage running and torque inputs intact
      class2_d = (ERR_CLASS == dosm_pkg::ERR_CLASS2) && running && sto_high;
    end
    else
    begin
      case (state_q)
        dosm_pkg::ST_START:
          if (ELEC_INIT_DONE) state_d = dosm_pkg::ST_NOT_READY;
        dosm_pkg::ST_NOT_READY:
          if (PARAM_INIT_DONE) state_d = dosm_pkg::ST_SWITCH_ON_DISABLED;
        dosm_pkg::ST_SWITCH_ON_DISABLED:
          if (!UNDERVOLTAGE && ENCODER_OK && slow && sto_high && (!shut_needed || c_shut))
            state_d = dosm_pkg::ST_READY;
        dosm_pkg::ST_READY:
          if (UNDERVOLTAGE || sto_low || fast || c_disv)
            state_d = dosm_pkg::ST_SWITCH_ON_DISABLED;
          else if (LOCAL_ENABLE_REQ || c_on)
          begin
            state_d = dosm_pkg::ST_SWITCHED_ON;
            via_fb_d = c_on && !LOCAL_ENABLE_REQ;
          end
        dosm_pkg::ST_SWITCHED_ON:
          if (LOCAL_DISABLE_REQ || c_disv)
            state_d = dosm_pkg::ST_SWITCH_ON_DISABLED;
          else if (c_shut)
            state_d = dosm_pkg::ST_READY;
          else if (!via_fb_q || c_enop)
            state_d = dosm_pkg::ST_OPERATION_ENABLED;
        dosm_pkg::ST_OPERATION_ENABLED:
          if (LOCAL_DISABLE_REQ || c_disv)
            state_d = dosm_pkg::ST_SWITCH_ON_DISABLED;
          else if (c_shut)
            state_d = dosm_pkg::ST_READY;
          else if (ERR_CLASS == dosm_pkg::ERR_CLASS1 || c_qs)
          begin
            state_d = dosm_pkg::ST_QUICK_STOP_ACTIVE;
            qs_fb_d = c_qs && ERR_CLASS != dosm_pkg::ERR_CLASS1;
          end
          else if (c_disop)
          begin
            state_d = dosm_pkg::ST_SWITCHED_ON;
            halt_d = 1'b1;
            via_fb_d = 1'b1;
          end
        dosm_pkg::ST_QUICK_STOP_ACTIVE:
          if (LOCAL_DISABLE_REQ || c_disv)
            state_d = dosm_pkg::ST_SWITCH_ON_DISABLED;
          else if (fault_reset || (c_enop && qs_fb_q))
            state_d = dosm_pkg::ST_OPERATION_ENABLED;
        dosm_pkg::ST_FAULT_RESPONSE_ACTIVE:
          if (!class2_q || ERR_RESPONSE_DONE)
            state_d = dosm_pkg::ST_FAULT;
        dosm_pkg::ST_FAULT:
          if (fault_reset)
          begin
            state_d = dosm_pkg::ST_SWITCH_ON_DISABLED;
            err_clr_d = 1'b1;
          end
        default: state_d = dosm_pkg::ST_START;
      endcase
    end
  end

  // ****************************************
  // Outputs derived from next state
  // ****************************************
  logic pwr_d;
  logic brake_d;
  logic valid_d;
  logic qs_d;
  logic pwr_q;
  logic brake_q;
  logic valid_q;
  logic qs_q;
  logic halt_q;
  logic err_clr_q;

  always_comb
  begin
    pwr_d = state_d == dosm_pkg::ST_OPERATION_ENABLED || state_d == dosm_pkg::ST_QUICK_STOP_ACTIVE
            || (state_d == dosm_pkg::ST_FAULT_RESPONSE_ACTIVE && class2_d);
    brake_d = state_d == dosm_pkg::ST_OPERATION_ENABLED
              || state_d == dosm_pkg::ST_QUICK_STOP_ACTIVE;
    valid_d = state_d == dosm_pkg::ST_OPERATION_ENABLED
              && state_q != dosm_pkg::ST_OPERATION_ENABLED;
    qs_d = state_d == dosm_pkg::ST_QUICK_STOP_ACTIVE
           || (state_d == dosm_pkg::ST_FAULT_RESPONSE_ACTIVE && class2_d);
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      state_q <= dosm_pkg::ST_START;
      via_fb_q <= 1'b0;
      qs_fb_q <= 1'b0;
      class2_q <= 1'b0;
      pwr_q <= 1'b0;
      brake_q <= 1'b0;
      valid_q <= 1'b0;
      qs_q <= 1'b0;
      halt_q <= 1'b0;
      err_clr_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_q <= state_d;
      via_fb_q <= via_fb_d;
      qs_fb_q <= qs_fb_d;
      class2_q <= class2_d;
      pwr_q <= pwr_d;
      brake_q <= brake_d;
      valid_q <= valid_d;
      qs_q <= qs_d;
      halt_q <= halt_d;
      err_clr_q <= err_clr_d;
    end
  end

  assign POWER_STAGE_EN = pwr_q;
  assign BRAKE_RELEASE = brake_q;
  assign PARAM_VALIDATE = valid_q;
  assign CANCEL_HALT = halt_q;
  assign CANCEL_QUICK_STOP = qs_q;
  assign ERROR_CLEAR = err_clr_q;
  assign STATE_NUM = 4'(state_q) + 4'h1;
  assign DRIVE_STATUS_WORD = status_of(state_q);

endmodule : dosm_sequencer

// >>> verif/dosm_checker_sva.sv
// Checker of the operating-state sequencer port behaviour
`timescale 1ns/100ps
module dosm_checker
(
  input wire logic CLOCK, // Clock
  input wire logic SYS_RST, // Reset
  input wire logic CLK_EN, // Enable
  input wire logic LOCAL_FAULT_RESET, // Fault reset
  input wire logic FIELDBUS_MODE, // Fieldbus mode
  input wire logic CMD_VALID, // Command strobe
  input wire logic [2:0] CMD_CODE, // Command code
  input wire logic [2:0] ERR_CLASS, // Error class
  input wire logic ERR_RESPONSE_DONE, // Braking done
  input wire logic POWER_STAGE_EN, // Power stage
  input wire logic BRAKE_RELEASE, // Brake
  input wire logic PARAM_VALIDATE, // Validate pulse
  input wire logic CANCEL_HALT, // Halt pulse
  input wire logic CANCEL_QUICK_STOP, // Quick stop
  input wire logic ERROR_CLEAR, // Error clear
  input wire logic [3:0] STATE_NUM, // State
  input wire logic [6:0] DRIVE_STATUS_WORD // Status
);
  // ****
  // Assertions
  // ****
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic fb_cmd;
  assign fb_cmd = CLK_EN && CMD_VALID && FIELDBUS_MODE;
  op_status_a: assert property (STATE_NUM == 4'h6 |-> DRIVE_STATUS_WORD == 7'h27 && POWER_STAGE_EN && BRAKE_RELEASE)
    else $error("operation enabled outputs wrong");
  qs_status_a: assert property (STATE_NUM == 4'h7 |-> DRIVE_STATUS_WORD == 7'h07 && CANCEL_QUICK_STOP)
    else $error("quick stop outputs wrong");
  enter_op_a: assert property (STATE_NUM == 4'h6 && $past(STATE_NUM) != 4'h6 |-> PARAM_VALIDATE)
    else $error("no parameter validation on entry");
  halt_cancel_a: assert property (STATE_NUM == 4'h6 && fb_cmd && CMD_CODE == 3'h4 && ERR_CLASS == 3'h0
    |=> STATE_NUM == 4'h5 && CANCEL_HALT && !POWER_STAGE_EN) else $error("disable operation wrong");
  qs_abort_a: assert property (STATE_NUM == 4'h7 && fb_cmd && CMD_CODE == 3'h5 && ERR_CLASS < 3'h2
    |=> STATE_NUM == 4'h3 && !POWER_STAGE_EN) else $error("quick stop abort wrong");
  fault_hold_a: assert property (STATE_NUM == 4'h9 && !LOCAL_FAULT_RESET && !(fb_cmd && CMD_CODE == 3'h7)
    |=> STATE_NUM == 4'h9) else $error("fault state left");
  fault_clear_a: assert property (STATE_NUM == 4'h9 && CLK_EN && LOCAL_FAULT_RESET
    |=> STATE_NUM == 4'h3 && ERROR_CLEAR) else $error("fault reset wrong");
  error_entry_a: assert property (CLK_EN && ERR_CLASS inside {3'h2, 3'h3, 3'h4} && STATE_NUM < 4'h8
    |=> STATE_NUM == 4'h8) else $error("error response not entered");
  hard_fault_a: assert property (CLK_EN && ERR_CLASS inside {3'h3, 3'h4} && STATE_NUM < 4'h8
    |=> !POWER_STAGE_EN and (CLK_EN |=> STATE_NUM == 4'h9)) else $error("hard fault wrong");
  class_two_a: assert property (STATE_NUM == 4'h6 && CLK_EN && ERR_CLASS == 3'h2
    |=> STATE_NUM == 4'h8 && CANCEL_QUICK_STOP && POWER_STAGE_EN && !BRAKE_RELEASE) else $error("class two wrong");
  soft_done_a: assert property (STATE_NUM == 4'h8 && CANCEL_QUICK_STOP && ERR_RESPONSE_DONE && CLK_EN
    |=> STATE_NUM == 4'h9 && !POWER_STAGE_EN) else $error("response end wrong");
  hard_response_a: assert property (STATE_NUM == 4'h8 && !CANCEL_QUICK_STOP |-> !POWER_STAGE_EN)
    else $error("hard response left power on");
endmodule : dosm_checker
bind dosm_sequencer dosm_checker dosm_checker_inst (.*);

// >>> verif/dosm_fb_master.sv
// Fieldbus master model issuing state-control commands
`timescale 1ns/100ps
module dosm_fb_master
(
  input wire logic clk, // Device clock
  output logic cmd_valid, // Command strobe
  output logic [2:0] cmd_code // Command code
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
  end
  // Strobe stands one cycle, then the code turns to junk
  always @(posedge clk)
    if (cmd_valid)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= ~cmd_code;
    end
  task automatic send(input logic [2:0] c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
  endtask : send
endmodule : dosm_fb_master

// >>> verif/test_drive_operating_state_machine.sv
// Testbench of the drive operating-state sequencer
`timescale 1ns/100ps
module test_drive_operating_state_machine;
  logic CLOCK, SYS_RST, CLK_EN, ELEC_INIT_DONE, PARAM_INIT_DONE, UNDERVOLTAGE, ENCODER_OK, FIELDBUS_MODE;
  logic SAFE_TORQUE_INPUT_A, SAFE_TORQUE_INPUT_B, LOCAL_ENABLE_REQ, LOCAL_DISABLE_REQ, LOCAL_FAULT_RESET;
  logic FIELDBUS_CANOPEN, CMD_VALID, ERR_RESPONSE_DONE, POWER_STAGE_EN, BRAKE_RELEASE;
  logic PARAM_VALIDATE, CANCEL_HALT, CANCEL_QUICK_STOP, ERROR_CLEAR;
  logic [15:0] SPEED_RPM;
  logic [1:0] PROFILE_COMPAT_SELECT;
  logic [2:0] CMD_CODE, ERR_CLASS;
  logic [3:0] STATE_NUM;
  logic [6:0] DRIVE_STATUS_WORD;
  int error_cnt, comparisons;
  dosm_sequencer dosm_sequencer_inst (.*);
  dosm_fb_master dosm_fb_master_inst (.clk(CLOCK), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE));
  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [6:0] sw(input logic [3:0] s);
    case (s)
      4'h3: return 7'h40;
      4'h4: return 7'h21;
      4'h5: return 7'h23;
      4'h6: return 7'h27;
      4'h7: return 7'h07;
      4'h8, 4'h9: return 7'h0f;
      default: return 7'h00;
    endcase
  endfunction : sw
  // Wait one edge, drop pulses, compare state, status and power
  task automatic exp(input logic [3:0] s);
    logic [1:0] pw;
    @(posedge CLOCK);
    {LOCAL_ENABLE_REQ, LOCAL_DISABLE_REQ, LOCAL_FAULT_RESET, ERR_RESPONSE_DONE} <= 4'h0;
    ERR_CLASS <= 3'h0;
    #1;
    pw = (s == 4'h8) ? 2'h0 : {POWER_STAGE_EN, BRAKE_RELEASE};
    comparisons++;
    if ({STATE_NUM, DRIVE_STATUS_WORD, pw} !== {s, sw(s), {2{s == 4'h6 || s == 4'h7}}})
    begin
      error_cnt++;
      $display("CHECK FAILED state expected %0d seen %0d, status/power expected %h seen %h", s, STATE_NUM,
               {sw(s), {2{s == 4'h6 || s == 4'h7}}}, {DRIVE_STATUS_WORD, pw});
    end
  endtask : exp
  // Compare power stage and the pulse outputs right after an exp
  task automatic outs(input logic [4:0] p);
    comparisons++;
    if ({POWER_STAGE_EN, PARAM_VALIDATE, CANCEL_HALT, CANCEL_QUICK_STOP, ERROR_CLEAR} !== p)
    begin
      error_cnt++;
      $display("CHECK FAILED outputs expected %b seen %b", p,
               {POWER_STAGE_EN, PARAM_VALIDATE, CANCEL_HALT, CANCEL_QUICK_STOP, ERROR_CLEAR});
    end
  endtask : outs
  task automatic bus(input logic [2:0] c, input logic [3:0] s);
    dosm_fb_master_inst.send(c);
    exp(s);
  endtask : bus
  task automatic results;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ****
  // Scenarios
  // ****
  task automatic t_power_up;
    @(posedge CLOCK) {ELEC_INIT_DONE, PARAM_INIT_DONE} <= 2'h3;
    exp(4'h2);
    exp(4'h3);
    exp(4'h3);
    @(posedge CLOCK) ENCODER_OK <= 1'b1;
    exp(4'h4);
    @(posedge CLOCK) SPEED_RPM <= 16'h03e8;
    exp(4'h4);
    @(posedge CLOCK) SPEED_RPM <= 16'h03e9;
    exp(4'h3);
    @(posedge CLOCK) SPEED_RPM <= 16'h03e8;
    exp(4'h3);
    @(posedge CLOCK) SPEED_RPM <= 16'h03e7;
    exp(4'h4);
    @(posedge CLOCK) UNDERVOLTAGE <= 1'b1;
    exp(4'h3);
    @(posedge CLOCK) UNDERVOLTAGE <= 1'b0;
    exp(4'h4);
    @(posedge CLOCK) {SAFE_TORQUE_INPUT_A, SAFE_TORQUE_INPUT_B} <= 2'h0;
    repeat (2) @(posedge CLOCK);
    exp(4'h3);
    @(posedge CLOCK) {SAFE_TORQUE_INPUT_A, SAFE_TORQUE_INPUT_B} <= 2'h3;
    repeat (2) @(posedge CLOCK);
    exp(4'h4);
  endtask : t_power_up
  task automatic t_local_and_bus;
    @(posedge CLOCK) LOCAL_ENABLE_REQ <= 1'b1;
    exp(4'h5);
    exp(4'h6);
    outs(5'h18);
    @(posedge CLOCK) LOCAL_DISABLE_REQ <= 1'b1;
    exp(4'h3);
    exp(4'h4);
    bus(3'h3, 4'h4);
    bus(3'h2, 4'h5);
    exp(4'h5);
    bus(3'h3, 4'h6);
    bus(3'h4, 4'h5);
    outs(5'h04);
    exp(4'h5);
    outs(5'h00);
    bus(3'h1, 4'h4);
    bus(3'h2, 4'h5);
    bus(3'h5, 4'h3);
    exp(4'h4);
    bus(3'h2, 4'h5);
    @(posedge CLOCK) LOCAL_DISABLE_REQ <= 1'b1;
    exp(4'h3);
    exp(4'h4);
    @(posedge CLOCK) FIELDBUS_MODE <= 1'b0;
    bus(3'h2, 4'h4);
    @(posedge CLOCK) FIELDBUS_MODE <= 1'b1;
  endtask : t_local_and_bus
  task automatic t_quick_stop;
    bus(3'h2, 4'h5);
    bus(3'h3, 4'h6);
    @(posedge CLOCK) ERR_CLASS <= 3'h1;
    exp(4'h7);
    outs(5'h12);
    bus(3'h3, 4'h7);
    @(posedge CLOCK) LOCAL_FAULT_RESET <= 1'b1;
    exp(4'h6);
    bus(3'h6, 4'h7);
    bus(3'h3, 4'h6);
    bus(3'h6, 4'h7);
    bus(3'h5, 4'h3);
    exp(4'h4);
    bus(3'h2, 4'h5);
    bus(3'h3, 4'h6);
    bus(3'h1, 4'h4);
    bus(3'h2, 4'h5);
    bus(3'h3, 4'h6);
    bus(3'h5, 4'h3);
    exp(4'h4);
  endtask : t_quick_stop
  task automatic t_faults;
    bus(3'h2, 4'h5);
    bus(3'h3, 4'h6);
    @(posedge CLOCK) ERR_CLASS <= 3'h2;
    exp(4'h8);
    outs(5'h12);
    exp(4'h8);
    outs(5'h12);
    @(posedge CLOCK) ERR_RESPONSE_DONE <= 1'b1;
    exp(4'h9);
    outs(5'h00);
    @(posedge CLOCK) ERR_CLASS <= 3'h3;
    exp(4'h9);
    bus(3'h7, 4'h3);
    outs(5'h01);
    exp(4'h4);
    @(posedge CLOCK) ERR_CLASS <= 3'h3;
    exp(4'h8);
    outs(5'h00);
    exp(4'h9);
    @(posedge CLOCK) LOCAL_FAULT_RESET <= 1'b1;
    exp(4'h3);
    @(posedge CLOCK) ERR_CLASS <= 3'h4;
    exp(4'h8);
    exp(4'h9);
    bus(3'h7, 4'h3);
    @(posedge CLOCK) {FIELDBUS_CANOPEN, PROFILE_COMPAT_SELECT} <= 3'h5;
    bus(3'h5, 4'h3);
    exp(4'h3);
    bus(3'h1, 4'h4);
  endtask : t_faults
  // Frozen clock enable, torque-input trip while running, reset in mid-run
  task automatic t_trip_and_reset;
    bus(3'h2, 4'h5);
    bus(3'h3, 4'h6);
    @(posedge CLOCK) {CLK_EN, LOCAL_DISABLE_REQ} <= 2'h1;
    exp(4'h6);
    @(posedge CLOCK) CLK_EN <= 1'b1;
    exp(4'h6);
    @(posedge CLOCK) {SAFE_TORQUE_INPUT_A, SAFE_TORQUE_INPUT_B} <= 2'h0;
    repeat (2) @(posedge CLOCK);
    exp(4'h8);
    outs(5'h00);
    exp(4'h9);
    @(posedge CLOCK) {SAFE_TORQUE_INPUT_A, SAFE_TORQUE_INPUT_B} <= 2'h3;
    @(posedge CLOCK) LOCAL_FAULT_RESET <= 1'b1;
    exp(4'h3);
    bus(3'h1, 4'h4);
    bus(3'h2, 4'h5);
    bus(3'h3, 4'h6);
    @(posedge CLOCK) SYS_RST <= 1'b1;
    exp(4'h1);
    outs(5'h00);
    @(posedge CLOCK) SYS_RST <= 1'b0;
    exp(4'h2);
    exp(4'h3);
    exp(4'h3);
    bus(3'h1, 4'h4);
  endtask : t_trip_and_reset
  initial
  begin
    {SYS_RST, CLK_EN, SAFE_TORQUE_INPUT_A, SAFE_TORQUE_INPUT_B, FIELDBUS_MODE} = 5'h1f;
    {ELEC_INIT_DONE, PARAM_INIT_DONE, UNDERVOLTAGE, ENCODER_OK, LOCAL_ENABLE_REQ} = 5'h00;
    {LOCAL_DISABLE_REQ, LOCAL_FAULT_RESET, FIELDBUS_CANOPEN, ERR_RESPONSE_DONE} = 4'h0;
    SPEED_RPM = 16'h0064;
    PROFILE_COMPAT_SELECT = 2'h0;
    ERR_CLASS = 3'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    exp(4'h1);
    t_power_up();
    t_local_and_bus();
    t_quick_stop();
    t_faults();
    t_trip_and_reset();
    results();
  end
  initial
  begin
    #200000;
    error_cnt++;
    results();
  end
endmodule : test_drive_operating_state_machine
